// ===== inc/meter_cfg.svh
// Constants of the meter info and display register bank.
// Assumes a 100 MHz ref_clk and one 32-bit item per two-word access.
// Functional notes
// - Date reads as packed BCD YYYYMMDD.
// - Time reads as BCD HHMMSS, top byte zero.
// - Fault bitmap, each one bit flags error.
// - Diameter reads as integer, zero to thousand.
// - Firmware checksum read-only, limited to sixteen bits.
// - Count excitations since last battery exchange.
// - Battery exchange date kept as BCD YYYYMMDD.
// - Remaining charge in mAh, unsigned 32 bits.
// - Remaining charge percent, limited to hundred.
// - Count minutes suspended by error condition.
// - Count minutes of correct measurement separately.
// - Flow unit code zero to four, default three-cubic.
// - Volume unit code zero to three, default cubic.
// - Temperature unit: zero Celsius, one Fahrenheit.
// - Pressure unit: zero bar, one psi.
// - Language code zero to five, English default.
// - Backlight lit programmed seconds, zero means off.
// - Display timeout rounded to multiple of five.
// - Display timeout zero keeps display always on.
// - Two words at even register, else exception two.
`ifndef METER_CFG_SVH
`define METER_CFG_SVH
// Item geometry and answers
`define ITEM_WORDS        8'h02
`define EXC_NONE          8'h00
`define EXC_BAD_ADDR      8'h02
// Information items, zero-based word addresses
`define ADDR_CUR_DATE     16'h03e7
`define ADDR_CUR_TIME     16'h03e9
`define ADDR_SERIAL       16'h03eb
`define ADDR_FAULTS       16'h03ed
`define ADDR_DIAMETER     16'h03ef
`define ADDR_NOM_FLOW     16'h03f1
`define ADDR_FW_VERSION   16'h03f3
`define ADDR_EXCIT        16'h03f5
`define ADDR_FW_SUM       16'h03f7
`define ADDR_BATT_DATE    16'h03f9
`define ADDR_BATT_MAH     16'h03fb
`define ADDR_BATT_PCT     16'h03fd
`define ADDR_FAULT_MIN    16'h03ff
`define ADDR_GOOD_MIN     16'h0401
`define ADDR_FW_RELEASE   16'h0403
// Display settings
`define ADDR_FLOW_UNIT    16'h05db
`define ADDR_VOL_UNIT     16'h05dd
`define ADDR_TEMP_UNIT    16'h05df
`define ADDR_PRESS_UNIT   16'h05e1
`define ADDR_LANGUAGE     16'h05e3
`define ADDR_CONTRAST     16'h05e5
`define ADDR_BACKLIGHT    16'h05e7
`define ADDR_DISP_TIME    16'h05e9
// Reset values
`define RST_FLOW_UNIT     3'h2
`define RST_VOL_UNIT      2'h2
`define RST_CONTRAST      7'h19
`define RST_DISP_TIME     22'h00001e
// Upper limits of values
`define MAX_FLOW_UNIT     32'h00000004
`define MAX_VOL_UNIT      32'h00000003
`define MAX_BIN_UNIT      32'h00000001
`define MAX_LANGUAGE      32'h00000005
`define MAX_CONTRAST      32'h00000064
`define MAX_BACKLIGHT     32'h0000001e
`define MAX_DISP_TIME     32'h0020c498
`define MAX_DIAMETER      32'h000003e8
`define MAX_PERCENT       32'h00000064
`define DISP_STEP         32'h00000005
// Timing
`define CLK_PERIOD_NS     10
`define SECOND_NS         1000000000
`define SECOND_CYCLES     (`SECOND_NS / `CLK_PERIOD_NS)
`define MINUTE_SECONDS    6'h3c
`endif

// ===== inc/meter_pkg.sv
// Types of the meter info and display register bank.
// Assumes the constants come from meter_cfg.svh.
package meter_pkg;
    // Whole state of the register bank top
    typedef struct packed {
        logic [1:0]  btnSync;
        logic        btnPrev;
        logic        btnPress;
        logic [26:0] secCnt;
        logic [5:0]  minCnt;
        logic        secTick;
        logic        minTick;
        logic [2:0]  flowUnit;
        logic [1:0]  volumeUnit;
        logic        tempUnit;
        logic        pressUnit;
        logic [2:0]  language;
        logic [6:0]  contrast;
        logic [4:0]  backlight;
        logic [21:0] dispTime;
        logic [31:0] battDate;
        logic        rspValid;
        logic [31:0] rspData;
        logic [7:0]  rspExc;
    } regs_state_t;
    // State of one event counter
    typedef struct packed {
        logic [31:0] count;
    } counter_state_t;
    // State of one seconds timer
    typedef struct packed {
        logic [21:0] remain;
    } timer_state_t;
endpackage : meter_pkg

// ===== inc/sec_timer_if.sv
// Carrier between the register bank and a seconds timer.
// Assumes tick is a one-cycle pulse once a second.
`timescale 1ns/1ps
interface sec_timer_if;
    logic        load;     // Restart pulse
    logic [21:0] seconds;  // Seconds to run
    logic        tick;     // One-second pulse
    logic        active;   // Timer still running
    modport owner (output load, output seconds, output tick, input active);
    modport timer (input load, input seconds, input tick, output active);
endinterface : sec_timer_if

// ===== core/event_counter.sv
// Unsigned 32-bit event counter with synchronous clear.
// Assumes clr and inc come from logic on ref_clk.
`timescale 1ns/1ps
module event_counter
    import meter_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Events
    input  wire logic        clr,
    input  wire logic        inc,
    // Result
    output logic      [31:0] count
);
    counter_state_t s_q;  // Registered state
    counter_state_t s_d;  // Next state

    // Clear wins over a count in the same cycle
    always_comb
    begin
        s_d = s_q;
        if (clr)
            s_d.count = 32'h0;
        else if (inc)
            s_d.count = s_q.count + 32'h1;
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign count = s_q.count;

    AST_CNT_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
        inc && !clr |=> count == $past(count) + 32'h1)
        else $error("counter missed an event");
endmodule : event_counter

// ===== core/sec_timer.sv
// Seconds down-counter restarted by a load pulse.
// Assumes the first tick after a load may come early by under a second.
`timescale 1ns/1ps
module sec_timer
    import meter_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Control and status
    sec_timer_if.timer tmr
);
    timer_state_t s_q;  // Registered state
    timer_state_t s_d;  // Next state

    // Load restarts, each tick takes one second off
    always_comb
    begin
        s_d = s_q;
        if (tmr.load)
            s_d.remain = tmr.seconds;
        else if (tmr.tick && (s_q.remain != 22'h0))
            s_d.remain = s_q.remain - 22'h1;
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tmr.active = (s_q.remain != 22'h0);

    AST_TMR_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
        tmr.load |=> s_q.remain == $past(tmr.seconds))
        else $error("timer did not take its load");
endmodule : sec_timer

// ===== core/meter_info_display_regs.sv
// Info and display register bank of the flow meter, served per item.
// Assumes a decoded request: start word address, word count, 32-bit data.
`timescale 1ns/1ps
`include "meter_cfg.svh"
module meter_info_display_regs
    import meter_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `SECOND_CYCLES
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Item request
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqCount,
    input  wire logic [31:0] reqWrData,
    // Item answer
    output logic             rspValid,
    output logic      [31:0] rspData,
    output logic      [7:0]  rspException,
    // Meter state
    input  wire logic [31:0] curDate,
    input  wire logic [31:0] curTime,
    input  wire logic [31:0] serialNumber,
    input  wire logic [31:0] faultBits,
    input  wire logic [31:0] diameterIn,
    input  wire logic [31:0] nominalFlow,
    input  wire logic [31:0] firmwareVersion,
    input  wire logic [15:0] firmwareSum,
    input  wire logic [31:0] chargeMah,
    input  wire logic [31:0] chargePercent,
    input  wire logic [31:0] releaseVersion,
    // Meter events
    input  wire logic        excitationPulse,
    input  wire logic        batteryExchange,
    input  wire logic        measureOk,
    input  wire logic        measureFault,
    // Front-panel button pin
    input  wire logic        buttonPin,
    // Display settings
    output logic      [2:0]  flowUnit,
    output logic      [1:0]  volumeUnit,
    output logic             tempFahrenheit,
    output logic             pressPsi,
    output logic      [2:0]  menuLanguage,
    output logic             languageSpanish,
    output logic      [6:0]  displayContrast,
    output logic             backlightOn,
    output logic             displayOn
);
    regs_state_t s_q;           // Registered state
    regs_state_t s_d;           // Next state
    logic [31:0] excitCount;    // Excitations since battery exchange
    logic [31:0] faultMinutes;  // Minutes lost to faults
    logic [31:0] goodMinutes;   // Minutes measured correctly

    sec_timer_if blIf ();       // Backlight timer link
    sec_timer_if dispIf ();     // Display timer link

    // Excitation count restarts with a new battery
    // count excitations
    event_counter excitCounter (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clr     (batteryExchange),
        .inc     (excitationPulse),
        .count   (excitCount)
    );

    // Minutes with measurement suspended
    // fault minutes
    event_counter faultCounter (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clr     (1'b0),
        .inc     (s_q.minTick && measureFault),
        .count   (faultMinutes)
    );

    // Minutes with good measurement
    // good minutes
    event_counter goodCounter (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clr     (1'b0),
        .inc     (s_q.minTick && measureOk && !measureFault),
        .count   (goodMinutes)
    );

    // Backlight runs from a button press
    assign blIf.load      = s_q.btnPress;
    assign blIf.seconds   = {17'h0, s_q.backlight};
    assign blIf.tick      = s_q.secTick;
    sec_timer backlightTimer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tmr     (blIf)
    );

    // Display stays awake after a button press
    assign dispIf.load    = s_q.btnPress;
    assign dispIf.seconds = s_q.dispTime;
    assign dispIf.tick    = s_q.secTick;
    sec_timer displayTimer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tmr     (dispIf)
    );

    // Next-state logic of the whole bank
    always_comb
    begin
        logic [31:0] wv;     // Clamped write value
        logic [31:0] rdData; // Item selected for a read
        logic        rdHit;  // Read address is mapped
        logic        legal;  // Two words at an even register
        wv     = 32'h0;
        rdData = 32'h0;
        rdHit  = 1'b1;
        legal  = 1'b0;
        s_d    = s_q;

        // Button pin synchroniser and press edge
        s_d.btnSync  = {s_q.btnSync[0], buttonPin};
        s_d.btnPrev  = s_q.btnSync[1];
        s_d.btnPress = s_q.btnSync[1] & ~s_q.btnPrev;

        // Second and minute ticks
        s_d.secTick = 1'b0;
        s_d.minTick = 1'b0;
        if (s_q.secCnt == 27'(SEC_CYCLES - 1))
        begin
            s_d.secCnt  = 27'h0;
            s_d.secTick = 1'b1;
        end
        else
            s_d.secCnt = s_q.secCnt + 27'h1;
        if (s_q.secTick)
        begin
            if (s_q.minCnt == (`MINUTE_SECONDS - 6'h1))
            begin
                s_d.minCnt  = 6'h0;
                s_d.minTick = 1'b1;
            end
            else
                s_d.minCnt = s_q.minCnt + 6'h1;
        end

        // Battery exchange takes today's date
        // capture exchange date
        if (batteryExchange)
            s_d.battDate = curDate;

        // Read selection, address decode
        if (reqAddr == `ADDR_CUR_DATE)
            rdData = curDate;  // BCD date
        else if (reqAddr == `ADDR_CUR_TIME)
            rdData = {8'h0, curTime[23:0]};  // top byte zero
        else if (reqAddr == `ADDR_SERIAL)
            rdData = serialNumber;
        else if (reqAddr == `ADDR_FAULTS)
            rdData = faultBits;  // error bitmap
        else if (reqAddr == `ADDR_DIAMETER)
            rdData = (diameterIn > `MAX_DIAMETER) ? `MAX_DIAMETER : diameterIn;  // clamp
        else if (reqAddr == `ADDR_NOM_FLOW)
            rdData = nominalFlow;
        else if (reqAddr == `ADDR_FW_VERSION)
            rdData = firmwareVersion;
        else if (reqAddr == `ADDR_EXCIT)
            rdData = excitCount;
        else if (reqAddr == `ADDR_FW_SUM)
            rdData = {16'h0, firmwareSum};  // sixteen bits
        else if (reqAddr == `ADDR_BATT_DATE)
            rdData = s_q.battDate;
        else if (reqAddr == `ADDR_BATT_MAH)
            rdData = chargeMah;  // charge mAh
        else if (reqAddr == `ADDR_BATT_PCT)
            rdData = (chargePercent > `MAX_PERCENT) ? `MAX_PERCENT : chargePercent;  // clamp
        else if (reqAddr == `ADDR_FAULT_MIN)
            rdData = faultMinutes;
        else if (reqAddr == `ADDR_GOOD_MIN)
            rdData = goodMinutes;
        else if (reqAddr == `ADDR_FW_RELEASE)
            rdData = releaseVersion;
        else if (reqAddr == `ADDR_FLOW_UNIT)
            rdData = {29'h0, s_q.flowUnit};
        else if (reqAddr == `ADDR_VOL_UNIT)
            rdData = {30'h0, s_q.volumeUnit};
        else if (reqAddr == `ADDR_TEMP_UNIT)
            rdData = {31'h0, s_q.tempUnit};
        else if (reqAddr == `ADDR_PRESS_UNIT)
            rdData = {31'h0, s_q.pressUnit};
        else if (reqAddr == `ADDR_LANGUAGE)
            rdData = {29'h0, s_q.language};
        else if (reqAddr == `ADDR_CONTRAST)
            rdData = {25'h0, s_q.contrast};
        else if (reqAddr == `ADDR_BACKLIGHT)
            rdData = {27'h0, s_q.backlight};
        else if (reqAddr == `ADDR_DISP_TIME)
            rdData = {10'h0, s_q.dispTime};
        else
            rdHit = 1'b0;

        // Access shape check
        // two words even
        legal = (reqCount == `ITEM_WORDS) && reqAddr[0];

        // Answer one cycle after each request
        s_d.rspValid = reqValid;
        if (reqValid)
        begin
            s_d.rspData = 32'h0;
            s_d.rspExc  = `EXC_NONE;
            if (!legal)
                s_d.rspExc = `EXC_BAD_ADDR;
            else if (!reqWrite)
            begin
                if (rdHit)
                    s_d.rspData = rdData;
                else
                    s_d.rspExc = `EXC_BAD_ADDR;
            end
            // Settings writes; values above range clamp to the top
            // flow unit
            else if (reqAddr == `ADDR_FLOW_UNIT)
            begin
                wv = (reqWrData > `MAX_FLOW_UNIT) ? `MAX_FLOW_UNIT : reqWrData;
                s_d.flowUnit = wv[2:0];
            end
            else if (reqAddr == `ADDR_VOL_UNIT)
            begin
                wv = (reqWrData > `MAX_VOL_UNIT) ? `MAX_VOL_UNIT : reqWrData;
                s_d.volumeUnit = wv[1:0];
            end
            else if (reqAddr == `ADDR_TEMP_UNIT)
            begin
                wv = (reqWrData > `MAX_BIN_UNIT) ? `MAX_BIN_UNIT : reqWrData;
                s_d.tempUnit = wv[0];
            end
            else if (reqAddr == `ADDR_PRESS_UNIT)
            begin
                wv = (reqWrData > `MAX_BIN_UNIT) ? `MAX_BIN_UNIT : reqWrData;
                s_d.pressUnit = wv[0];
            end
            else if (reqAddr == `ADDR_LANGUAGE)
            begin
                wv = (reqWrData > `MAX_LANGUAGE) ? `MAX_LANGUAGE : reqWrData;
                s_d.language = wv[2:0];
            end
            // Contrast in percent
            else if (reqAddr == `ADDR_CONTRAST)
            begin
                wv = (reqWrData > `MAX_CONTRAST) ? `MAX_CONTRAST : reqWrData;
                s_d.contrast = wv[6:0];
            end
            else if (reqAddr == `ADDR_BACKLIGHT)
            begin
                wv = (reqWrData > `MAX_BACKLIGHT) ? `MAX_BACKLIGHT : reqWrData;
                s_d.backlight = wv[4:0];
            end
            else if (reqAddr == `ADDR_DISP_TIME)
            begin
                wv = (reqWrData > `MAX_DISP_TIME) ? `MAX_DISP_TIME : reqWrData;
                wv = wv - (wv % `DISP_STEP);
                s_d.dispTime = wv[21:0];
            end
            // Information items and holes refuse writes
            // read-only info
            else
                s_d.rspExc = `EXC_BAD_ADDR;
        end
    end

    // State register with documented defaults
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q            <= '0;
            s_q.flowUnit   <= `RST_FLOW_UNIT;
            s_q.volumeUnit <= `RST_VOL_UNIT;
            s_q.contrast   <= `RST_CONTRAST;
            s_q.dispTime   <= `RST_DISP_TIME;
        end
        else
            s_q <= s_d;
    end

    // Outputs
    assign rspValid        = s_q.rspValid;
    assign rspData         = s_q.rspData;
    assign rspException    = s_q.rspExc;
    assign flowUnit        = s_q.flowUnit;
    assign volumeUnit      = s_q.volumeUnit;
    assign tempFahrenheit  = s_q.tempUnit;
    assign pressPsi        = s_q.pressUnit;
    assign menuLanguage    = s_q.language;
    assign displayContrast = s_q.contrast;
    // Only English and Spanish menus exist; other codes show English
    assign languageSpanish = (s_q.language == 3'h1);
    assign backlightOn     = blIf.active && (s_q.backlight != 5'h0);
    assign displayOn       = (s_q.dispTime == 22'h0) || dispIf.active;

    // Request shapes
    sequence sBadShape;
        reqValid && !((reqCount == `ITEM_WORDS) && reqAddr[0]);
    endsequence
    sequence sInfoWrite;
        reqValid && reqWrite && (reqAddr < `ADDR_FLOW_UNIT) && !batteryExchange;
    endsequence
    sequence sReadOf(logic [15:0] a);
        reqValid && !reqWrite && (reqCount == `ITEM_WORDS) && (reqAddr == a);
    endsequence

    AST_RSP_NEXT: assert property (@(posedge ref_clk) disable iff (!resetn)
        reqValid |=> rspValid ##1 (rspValid == $past(reqValid)))
        else $error("answer not one cycle after request");
    AST_BAD_SHAPE: assert property (@(posedge ref_clk) disable iff (!resetn)
        sBadShape |=> rspException == `EXC_BAD_ADDR && rspData == 32'h0)
        else $error("bad access shape not refused");
    AST_INFO_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
        sInfoWrite |=> $stable(s_q.battDate) && rspException != `EXC_NONE)
        else $error("information write was accepted");
    AST_TIME_TOP: assert property (@(posedge ref_clk) disable iff (!resetn)
        sReadOf(`ADDR_CUR_TIME) |=> rspData[31:24] == 8'h0 && rspData[23:0] == $past(curTime[23:0]))
        else $error("time top byte not zero");
    AST_PCT_MAX: assert property (@(posedge ref_clk) disable iff (!resetn)
        sReadOf(`ADDR_BATT_PCT) |=> rspData <= `MAX_PERCENT)
        else $error("charge percent above hundred");
    AST_DISP_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
        reqValid && reqWrite && (reqCount == `ITEM_WORDS) && (reqAddr == `ADDR_DISP_TIME)
        && (reqWrData < `MAX_DISP_TIME) |=> s_q.dispTime == 22'($past(reqWrData) - ($past(reqWrData) % `DISP_STEP)))
        else $error("display timeout not rounded to five");
    AST_DISP_ON: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.dispTime == 22'h0 |-> displayOn)
        else $error("display off with zero timeout");
    AST_BL_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.backlight == 5'h0 |-> !backlightOn)
        else $error("backlight lit with zero time");
    AST_BATT_DATE: assert property (@(posedge ref_clk) disable iff (!resetn)
        batteryExchange |=> s_q.battDate == $past(curDate) ##1 excitCount <= 32'h1)
        else $error("battery exchange not recorded");
endmodule : meter_info_display_regs

// ===== tb/item_master.sv
// Model of the remote master that sends whole items to the register bank.
// Assumes requests launch on the falling edge of ref_clk, one pulse each.
`timescale 1ns/1ps
module item_master
(
    // Clock
    input  wire logic        ref_clk,
    // Item request
    output logic             reqValid,
    output logic             reqWrite,
    output logic      [15:0] reqAddr,
    output logic      [7:0]  reqCount,
    output logic      [31:0] reqWrData
);
    // Quiet bus at time zero
    initial
    begin
        reqValid  = 1'b0;
        reqWrite  = 1'b0;
        reqAddr   = 16'h0000;
        reqCount  = 8'h00;
        reqWrData = 32'h00000000;
    end
    task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] c, input logic [31:0] d);
        @(negedge ref_clk);
        reqValid  = 1'b1;
        reqWrite  = w;
        reqAddr   = a;
        reqCount  = c;
        reqWrData = d;
    endtask : issue
    // Release, data inverted
    task automatic idle;
        @(negedge ref_clk);
        reqValid  = 1'b0;
        reqWrData = ~reqWrData;
    endtask : idle
endmodule : item_master

// ===== tb/tb_meter_info_display_regs.sv
// Self-checking bench of the meter info and display register bank.
// Assumes the item master model drives requests on the falling edge.
`timescale 1ns/1ps
`include "meter_cfg.svh"
module tb_meter_info_display_regs;
    logic ref_clk = 1'b0, resetn = 1'b0; // Clock and reset
    logic reqValid, reqWrite, rspValid, tempFahrenheit, pressPsi, languageSpanish, backlightOn, displayOn;
    logic [15:0] reqAddr;                // Request address
    logic [7:0]  reqCount, rspException; // Counts and answer code
    logic [31:0] reqWrData, rspData;     // Item data
    logic [31:0] curDate = 32'h20100325, curTime = 32'hff083315, serialNumber = 32'h0, faultBits = 32'h0;
    logic [31:0] diameterIn = 32'h0, nominalFlow = 32'h0, firmwareVersion = 32'h0, chargeMah = 32'h0;
    logic [31:0] chargePercent = 32'h0, releaseVersion = 32'h0;
    logic [15:0] firmwareSum = 16'hbeef; // Checksum input
    logic excitationPulse = 1'b0, batteryExchange = 1'b0, measureOk = 1'b0, measureFault = 1'b0, buttonPin = 1'b0;
    logic [2:0]  flowUnit, menuLanguage; // Settings seen
    logic [1:0]  volumeUnit;
    logic [6:0]  displayContrast;
    logic [39:0] expq[$];                // Notes of expected answers
    int miscompares = 0, comparisons = 0, seed = 32'hb518;
    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    item_master item_master_i (.ref_clk, .reqValid, .reqWrite, .reqAddr, .reqCount, .reqWrData);
    meter_info_display_regs #(.SEC_CYCLES(10)) meter_info_display_regs_i (.ref_clk, .resetn, .reqValid,
        .reqWrite, .reqAddr, .reqCount, .reqWrData, .rspValid, .rspData, .rspException, .curDate, .curTime,
        .serialNumber, .faultBits, .diameterIn, .nominalFlow, .firmwareVersion, .firmwareSum, .chargeMah,
        .chargePercent, .releaseVersion, .excitationPulse, .batteryExchange, .measureOk, .measureFault,
        .buttonPin, .flowUnit, .volumeUnit, .tempFahrenheit, .pressPsi, .menuLanguage, .languageSpanish,
        .displayContrast, .backlightOn, .displayOn);
    // Compare one value and count it
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Note the answer, then send one item
    task automatic req(input logic w, input logic [15:0] a, input logic [7:0] c, input logic [31:0] d,
                       input logic [31:0] ed, input logic [7:0] ee);
        expq.push_back({ee, ed});
        item_master_i.issue(w, a, c, d);
        item_master_i.idle();
    endtask : req
    // Verdict and end of run
    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // Monitor takes the oldest note at every answer
    always @(negedge ref_clk)
    begin
        if (rspValid === 1'b1)
            check("answer", {rspException, rspData}, expq.pop_front());
    end
    // Main sequence
    initial
    begin
        logic [15:0] ra[8] = '{`ADDR_FLOW_UNIT, `ADDR_VOL_UNIT, `ADDR_TEMP_UNIT, `ADDR_PRESS_UNIT,
                               `ADDR_LANGUAGE, `ADDR_CONTRAST, `ADDR_BACKLIGHT, `ADDR_DISP_TIME};
        logic [31:0] rv[8] = '{32'h2, 32'h2, 32'h0, 32'h0, 32'h0, 32'h19, 32'h0, 32'h1e};
        serialNumber = $random(seed);
        faultBits = $random(seed);
        chargeMah = $random(seed);
        diameterIn = 32'h00000400 | $random(seed);
        chargePercent = 32'h00000065 | $random(seed);
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        for (int k = 0; k < 8; k++) req(1'b0, ra[k], 8'h02, 32'h0, rv[k], 8'h00);
        expq.push_back({8'h00, curDate});
        expq.push_back({8'h00, 32'h00083315});
        item_master_i.issue(1'b0, `ADDR_CUR_DATE, 8'h02, 32'h0);
        item_master_i.issue(1'b0, `ADDR_CUR_TIME, 8'h02, 32'h0);
        item_master_i.idle();
        req(1'b0, `ADDR_SERIAL, 8'h02, 32'h0, serialNumber, 8'h00);
        req(1'b0, `ADDR_DIAMETER, 8'h02, 32'h0, 32'h3e8, 8'h00);
        req(1'b0, `ADDR_BATT_PCT, 8'h02, 32'h0, 32'h64, 8'h00);
        req(1'b0, `ADDR_FW_SUM, 8'h02, 32'h0, 32'h0000beef, 8'h00);
        req(1'b0, `ADDR_FAULTS, 8'h02, 32'h0, faultBits, 8'h00);
        req(1'b0, `ADDR_BATT_MAH, 8'h02, 32'h0, chargeMah, 8'h00);
        req(1'b0, `ADDR_CUR_DATE, 8'h01, 32'h0, 32'h0, 8'h02);
        req(1'b0, 16'h03e8, 8'h02, 32'h0, 32'h0, 8'h02);
        req(1'b1, `ADDR_FAULTS, 8'h02, 32'h5, 32'h0, 8'h02);
        req(1'b1, `ADDR_CONTRAST, 8'h03, 32'h40, 32'h0, 8'h02);
        req(1'b0, `ADDR_CONTRAST, 8'h02, 32'h0, 32'h19, 8'h00);
        // every flow unit code, then a clamped one
        for (int k = 0; k < 6; k++)
        begin
            req(1'b1, `ADDR_FLOW_UNIT, 8'h02, k, 32'h0, 8'h00);
            check("flowUnit", flowUnit, (k > 4) ? 3'h4 : k[2:0]);
        end
        // Spanish, then a stored future code
        req(1'b1, `ADDR_LANGUAGE, 8'h02, 32'h1, 32'h0, 8'h00);
        check("languageSpanish", languageSpanish, 1'b1);
        req(1'b1, `ADDR_LANGUAGE, 8'h02, 32'h5, 32'h0, 8'h00);
        req(1'b0, `ADDR_LANGUAGE, 8'h02, 32'h0, 32'h5, 8'h00);
        check("language", {menuLanguage, languageSpanish}, 4'ha);
        check("dark", {backlightOn, displayOn}, 2'h0);
        req(1'b1, `ADDR_VOL_UNIT, 8'h02, 32'h7, 32'h0, 8'h00);
        req(1'b1, `ADDR_TEMP_UNIT, 8'h02, 32'h2, 32'h0, 8'h00);
        req(1'b1, `ADDR_PRESS_UNIT, 8'h02, 32'h1, 32'h0, 8'h00);
        req(1'b1, `ADDR_CONTRAST, 8'h02, 32'h80, 32'h0, 8'h00);
        check("units", {volumeUnit, tempFahrenheit, pressPsi, displayContrast}, 11'h7e4);
        req(1'b1, `ADDR_DISP_TIME, 8'h02, 32'd33, 32'h0, 8'h00);
        req(1'b0, `ADDR_DISP_TIME, 8'h02, 32'h0, 32'd30, 8'h00);
        req(1'b1, `ADDR_BACKLIGHT, 8'h02, 32'h2, 32'h0, 8'h00);
        buttonPin = 1'b1;
        repeat (6) @(negedge ref_clk);
        check("lit", {backlightOn, displayOn}, 2'h3);
        repeat (30) @(negedge ref_clk);
        check("lit", {backlightOn, displayOn}, 2'h1);
        req(1'b1, `ADDR_DISP_TIME, 8'h02, 32'h0, 32'h0, 8'h00);
        check("displayOn", displayOn, 1'b1);
        excitationPulse = 1'b1;
        repeat (3) @(negedge ref_clk);
        excitationPulse = 1'b0;
        req(1'b0, `ADDR_EXCIT, 8'h02, 32'h0, 32'h3, 8'h00);
        batteryExchange = 1'b1;
        @(negedge ref_clk);
        batteryExchange = 1'b0;
        req(1'b0, `ADDR_EXCIT, 8'h02, 32'h0, 32'h0, 8'h00);
        req(1'b0, `ADDR_BATT_DATE, 8'h02, 32'h0, curDate, 8'h00);
        measureOk = 1'b1;
        repeat (600) @(negedge ref_clk);
        measureFault = 1'b1;
        repeat (600) @(negedge ref_clk);
        {measureOk, measureFault} = 2'b00;
        req(1'b0, `ADDR_GOOD_MIN, 8'h02, 32'h0, 32'h1, 8'h00);
        req(1'b0, `ADDR_FAULT_MIN, 8'h02, 32'h0, 32'h1, 8'h00);
        // Bounded drain of outstanding notes
        for (int k = 0; k < 20 && expq.size() > 0; k++) @(negedge ref_clk);
        if (expq.size() > 0) miscompares++;
        print_verdict();
    end
endmodule : tb_meter_info_display_regs
